// ---- include/rbsc_map.vh ----
// rbsc_map.vh: register offsets, field positions, reset values and timing
// for the reset and boot strap control block.
// assumes: included by bare name from the design files; definitions only.
`ifndef RBSC_MAP_VH
`define RBSC_MAP_VH

// apb address width and register byte offsets
`define RBSC_ADDR_W 4
`define RBSC_OFF_PUDR 4'h0
`define RBSC_OFF_OMR 4'h4
`define RBSC_OFF_STAT 4'h8

// pullup_disable_register fields, one bit per pad
`define RBSC_PUD_RESET 0
`define RBSC_PUD_IRQ 1
`define RBSC_PUD_BOOT 2
`define RBSC_PUD_WIDE 3
`define RBSC_PUD_RST_VAL 4'h0

// operating_mode_register fields
`define RBSC_OMR_MAP 0
`define RBSC_OMR_SECURE 1

// status register fields
`define RBSC_ST_BOOT_PIN 0
`define RBSC_ST_WIDE_PIN 1
`define RBSC_ST_WIDE_EN 2
`define RBSC_ST_SECURED 3
`define RBSC_ST_IN_RESET 4

// internal reset hold after release, in pclk cycles
`define RBSC_RELEASE_CYCLES 8'h20
`define RBSC_CNT_W 8

`endif

// ---- hdl/rbsc_sync.v ----
// rbsc_sync.v: two-flop synchroniser with asynchronous clear.
// assumes: d comes from outside the pclk domain; ce freezes both stages.
`timescale 1ns/1ps
`default_nettype none

module rbsc_sync (
	// clock, reset, enable
	input wire clk,
	input wire rst_n,
	input wire ce,
	// data
	input wire d,
	output reg q
);

reg meta_reg;

always @(posedge clk or negedge rst_n) begin
	if (!rst_n) begin
		meta_reg <= 1'b0;
		q <= 1'b0;
	end else if (ce) begin
		meta_reg <= d;
		q <= meta_reg;
	end
end

endmodule // rbsc_sync

`default_nettype wire

// ---- hdl/rbsc_top.v ----
// rbsc_top.v: chip reset sequencing, boot strap capture, pad pull-up control.
// assumes: apb master on pclk; reset pin, por and straps are asynchronous pins;
// flash_secured_in comes from pclk logic.
`timescale 1ns/1ps
`default_nettype none
`include "rbsc_map.vh"

module rbsc_top #(
	parameter [`RBSC_CNT_W-1:0] RELEASE_CYCLES = `RBSC_RELEASE_CYCLES
) (
	// clock, bus reset, clock enable
	input wire pclk,
	input wire presetn,
	input wire ce,
	// apb slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [`RBSC_ADDR_W-1:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	// reset sources
	input wire reset_pin_n,
	input wire por_n,
	// straps and flash state
	input wire external_boot_strap,
	input wire wide_address_strap,
	input wire flash_secured_in,
	// reset outputs
	output reg reset_state_out,
	output reg chip_reset_n,
	// operating mode outputs
	output reg external_boot_mode,
	output reg address_extend_en,
	// pad pull-up controls
	output reg pullup_off_reset,
	output reg pullup_off_irq,
	output reg boot_strap_pullup_off,
	output reg pullup_off_wide
);

// any source pulls every flop except the strap synchronisers, which clear on presetn alone, into reset at once
wire raw_rst_n;
assign raw_rst_n = presetn & por_n & reset_pin_n;

// release of the combined reset, brought onto pclk
wire release_sync;
rbsc_sync u_rel_sync (
	.clk(pclk),
	.rst_n(raw_rst_n),
	.ce(ce),
	.d(1'b1),
	.q(release_sync)
);

// strap pins are asynchronous, so each gets its own synchroniser
wire [1:0] strap_pins;
wire [1:0] strap_sync;
assign strap_pins = {wide_address_strap, external_boot_strap};

genvar gi;
generate
	for (gi = 0; gi < 2; gi = gi + 1) begin : g_strap
		rbsc_sync u_strap_sync (
			.clk(pclk),
			.rst_n(presetn),
			.ce(ce),
			.d(strap_pins[gi]),
			.q(strap_sync[gi])
		);
	end
endgenerate

wire boot_pin_s;
wire wide_pin_s;
assign boot_pin_s = strap_sync[0];
assign wide_pin_s = strap_sync[1];

// release sequencing
// the counter only runs once the synchronised release is seen, so a short
// glitch on any reset source restarts the whole hold from zero.
// the limit is a parameter so that a bench can shorten the hold.
reg release_d_reg;
reg [`RBSC_CNT_W-1:0] cnt_reg;
reg [`RBSC_CNT_W-1:0] cnt_next;
reg in_reset_reg;
reg in_reset_next;
wire release_edge;

assign release_edge = release_sync & ~release_d_reg;

always @* begin
	cnt_next = cnt_reg;
	in_reset_next = in_reset_reg;
	if (in_reset_reg && release_sync) begin
		if (cnt_reg >= RELEASE_CYCLES - 8'h01) begin
			in_reset_next = 1'b0;
		end else begin
			cnt_next = cnt_reg + 8'h01;
		end
	end
end

always @(posedge pclk or negedge raw_rst_n) begin
	if (!raw_rst_n) begin
		release_d_reg <= 1'b0;
		cnt_reg <= {`RBSC_CNT_W{1'b0}};
		in_reset_reg <= 1'b1;
		reset_state_out <= 1'b1;
		chip_reset_n <= 1'b0;
	end else if (ce) begin
		release_d_reg <= release_sync;
		cnt_reg <= cnt_next;
		in_reset_reg <= in_reset_next;
		reset_state_out <= in_reset_next;
		chip_reset_n <= ~in_reset_next;
	end
end

// operating mode register: secure bit is 1 when flash is unsecured
reg map_select_bit_reg;
reg secure_state_bit_reg;
reg wide_latched_reg;

// bus_access is the first access-phase cycle, where the answer is prepared;
// the write itself lands only at the edge where the master sees pready high,
// so a master that stalls or aborts before that edge changes nothing.
// writes that arrive while the chip is still held in reset are dropped,
// because the straps and the mode bits are not settled until release.
wire bus_write;
wire bus_access;
assign bus_access = psel & penable & ~pready;
assign bus_write = psel & penable & pready & pwrite & ~in_reset_reg;

always @(posedge pclk or negedge raw_rst_n) begin
	if (!raw_rst_n) begin
		map_select_bit_reg <= 1'b0;
		secure_state_bit_reg <= 1'b0;
		wide_latched_reg <= 1'b0;
	end else if (ce) begin
		if (release_edge) begin
			// a secured part never boots externally, whatever the strap says
			secure_state_bit_reg <= ~flash_secured_in;
			map_select_bit_reg <= boot_pin_s & ~flash_secured_in;
			wide_latched_reg <= wide_pin_s;
		end else if (bus_write && paddr == `RBSC_OFF_OMR) begin
			// the secure bit is read-only; only a reset reloads it
			map_select_bit_reg <= pwdata[`RBSC_OMR_MAP];
		end
	end
end

// mode outputs; map bit only acts when the part came up unsecured
always @(posedge pclk or negedge raw_rst_n) begin
	if (!raw_rst_n) begin
		external_boot_mode <= 1'b0;
		address_extend_en <= 1'b0;
	end else if (ce) begin
		external_boot_mode <= map_select_bit_reg & secure_state_bit_reg;
		address_extend_en <= wide_latched_reg & map_select_bit_reg & secure_state_bit_reg;
	end
end

// pull-up disable register, held at zero through reset
// a one turns a pad pull-up off; pads come up pulled so floating
// straps read high until firmware decides otherwise.
reg [3:0] pud_reg;

always @(posedge pclk or negedge raw_rst_n) begin
	if (!raw_rst_n) begin
		pud_reg <= `RBSC_PUD_RST_VAL;
	end else if (ce) begin
		if (bus_write && paddr == `RBSC_OFF_PUDR) begin
			pud_reg <= pwdata[3:0];
		end
	end
end

always @(posedge pclk or negedge raw_rst_n) begin
	if (!raw_rst_n) begin
		pullup_off_reset <= 1'b0;
		pullup_off_irq <= 1'b0;
		boot_strap_pullup_off <= 1'b0;
		pullup_off_wide <= 1'b0;
	end else if (ce) begin
		pullup_off_reset <= pud_reg[`RBSC_PUD_RESET];
		pullup_off_irq <= pud_reg[`RBSC_PUD_IRQ];
		boot_strap_pullup_off <= pud_reg[`RBSC_PUD_BOOT];
		pullup_off_wide <= pud_reg[`RBSC_PUD_WIDE];
	end
end

// apb read mux and decode
// unmapped offsets answer with an error; upper data bits always read zero.
reg [31:0] rdata_next;
reg slverr_next;

always @* begin
	rdata_next = 32'h00000000;
	slverr_next = 1'b0;
	case (paddr)
		`RBSC_OFF_PUDR: begin
			rdata_next[3:0] = pud_reg;
		end
		`RBSC_OFF_OMR: begin
			rdata_next[`RBSC_OMR_MAP] = map_select_bit_reg;
			rdata_next[`RBSC_OMR_SECURE] = secure_state_bit_reg;
		end
		`RBSC_OFF_STAT: begin
			rdata_next[`RBSC_ST_BOOT_PIN] = boot_pin_s;
			rdata_next[`RBSC_ST_WIDE_PIN] = wide_pin_s;
			rdata_next[`RBSC_ST_WIDE_EN] = address_extend_en;
			rdata_next[`RBSC_ST_SECURED] = flash_secured_in;
			rdata_next[`RBSC_ST_IN_RESET] = in_reset_reg;
		end
		default: begin
			slverr_next = 1'b1;
		end
	endcase
end

// one wait state: answer comes the cycle after the access phase starts
always @(posedge pclk or negedge raw_rst_n) begin
	if (!raw_rst_n) begin
		pready <= 1'b0;
		pslverr <= 1'b0;
		prdata <= 32'h00000000;
	end else if (ce) begin
		if (bus_access) begin
			pready <= 1'b1;
			pslverr <= slverr_next;
			prdata <= pwrite ? 32'h00000000 : rdata_next;
		end else begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
	end
end

endmodule // rbsc_top

`default_nettype wire

// ---- verif/rbsc_board.sv ----
// rbsc_board.sv: board-side model with the reset source, power-on cell and boot straps.
// assumes: the bench asks for reset with hold_rst; the straps are tied levels.
`timescale 1ns/1ps
`default_nettype none
module rbsc_board (
	// clock and bench requests
	input wire logic pclk,
	input wire logic hold_rst,
	input wire logic boot_lvl,
	input wire logic wide_lvl,
	// pins
	output logic reset_pin_n,
	output logic por_n,
	output logic external_boot_strap,
	output logic wide_address_strap
);
	logic [1:0] por_cnt = 2'h0;
	logic pin_q = 1'b1;
	always @(posedge pclk) begin
		if (por_cnt != 2'h3)
			por_cnt <= por_cnt + 2'h1;
		pin_q <= hold_rst; // reset pin alone, test reset untouched
	end
	assign reset_pin_n = ~pin_q;
	assign por_n = (por_cnt == 2'h3);
	// straps are tied solidly, so a pull-up never decides the level
	assign external_boot_strap = boot_lvl;
	assign wide_address_strap = wide_lvl;
endmodule // rbsc_board
`default_nettype wire

// ---- verif/rbsc_top_assertions.sv ----
// rbsc_top_assertions.sv: port-level properties of the reset and strap block.
// assumes: bound into rbsc_top; all properties on pclk.
`timescale 1ns/1ps
`default_nettype none
module rbsc_checker #(
	parameter [7:0] RELEASE_CYCLES = 8'h20
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [3:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic reset_pin_n,
	input wire logic por_n,
	input wire logic flash_secured_in,
	input wire logic reset_state_out,
	input wire logic chip_reset_n,
	input wire logic external_boot_mode,
	input wire logic address_extend_en,
	input wire logic pullup_off_reset,
	input wire logic pullup_off_irq,
	input wire logic boot_strap_pullup_off,
	input wire logic pullup_off_wide
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_rso; reset_state_out != chip_reset_n; endproperty
	a_rso: assert property (p_rso) else $error("reset outputs disagree");
	property p_pin; !reset_pin_n |-> reset_state_out; endproperty
	a_pin: assert property (p_pin) else $error("pin reset not held");
	property p_por; !por_n |-> reset_state_out; endproperty
	a_por: assert property (p_por) else $error("power-on reset not held");
	property p_hold; $rose(reset_pin_n) |-> reset_state_out [*3]; endproperty
	a_hold: assert property (p_hold) else $error("reset released early");
	property p_wide; address_extend_en |-> external_boot_mode; endproperty
	a_wide: assert property (p_wide) else $error("wide lines without external boot");
	property p_sec; reset_state_out && flash_secured_in |=> !external_boot_mode; endproperty
	a_sec: assert property (p_sec) else $error("secured part boots externally");
	property p_pud;
		ce && psel && penable && pwrite && pready && paddr == 4'h0 && !reset_state_out |-> ##2
		{pullup_off_wide, boot_strap_pullup_off, pullup_off_irq, pullup_off_reset} == $past(pwdata[3:0], 2);
	endproperty
	a_pud: assert property (p_pud) else $error("pull-up outputs wrong");
	property p_err; pready && paddr != 4'h0 && paddr != 4'h4 && paddr != 4'h8 |-> pslverr; endproperty
	a_err: assert property (p_err) else $error("unmapped access not refused");
endmodule // rbsc_checker
bind rbsc_top rbsc_checker #(.RELEASE_CYCLES(RELEASE_CYCLES)) u_chk (.pclk, .presetn, .ce, .psel, .penable,
	.pwrite, .paddr, .pwdata, .pready, .pslverr, .reset_pin_n, .por_n, .flash_secured_in, .reset_state_out,
	.chip_reset_n, .external_boot_mode, .address_extend_en, .pullup_off_reset, .pullup_off_irq,
	.boot_strap_pullup_off, .pullup_off_wide);
`default_nettype wire

// ---- verif/tb_reset_and_boot_strap_control.sv ----
// tb_reset_and_boot_strap_control.sv: self-checking bench for rbsc_top.
// assumes: RELEASE_CYCLES shortened to 2; ce held high throughout.
`timescale 1ns/1ps
`default_nettype none
module tb_reset_and_boot_strap_control;
	logic pclk, presetn, ce, psel, penable, pwrite, hold_rst, boot, wide, flash, e;
	logic [3:0] paddr;
	logic [31:0] pwdata, q;
	wire logic [31:0] prdata;
	wire logic pready, pslverr, rpin_n, por_n, bstrap, wstrap, rso, crst_n, ebm, aen, p0, p1, p2, p3;
	int n_errors = 0, num_checks = 0;
	// {boot, wide, flash, expected boot mode, expected extension}
	logic [4:0] rows [5] = '{5'b00000, 5'b10010, 5'b11011, 5'b11100, 5'b01000};
	rbsc_board u_board (.pclk(pclk), .hold_rst(hold_rst), .boot_lvl(boot), .wide_lvl(wide),
		.reset_pin_n(rpin_n), .por_n(por_n), .external_boot_strap(bstrap), .wide_address_strap(wstrap));
	rbsc_top #(.RELEASE_CYCLES(8'h02)) u_dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .reset_pin_n(rpin_n), .por_n(por_n), .external_boot_strap(bstrap),
		.wide_address_strap(wstrap), .flash_secured_in(flash), .reset_state_out(rso), .chip_reset_n(crst_n),
		.external_boot_mode(ebm), .address_extend_en(aen), .pullup_off_reset(p0), .pullup_off_irq(p1),
		.boot_strap_pullup_off(p2), .pullup_off_wide(p3));
	always #5 pclk = ~pclk;
	task chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task apb(input logic w, input logic [3:0] a, input logic [31:0] d);
		int i;
		psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		i = 0;
		do @(posedge pclk); while (pready !== 1'b1 && ++i < 50);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task print_verdict;
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial begin
		#100000;
		n_errors++;
		print_verdict;
	end
	initial begin
		pclk = 0; presetn = 0; ce = 1; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
		hold_rst = 1; boot = 0; wide = 0; flash = 0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		for (int r = 0; r < 5; r++) begin
			{boot, wide, flash} <= rows[r][4:2];
			hold_rst <= 1'b1;
			repeat (3) @(posedge pclk);
			hold_rst <= 1'b0;
			for (int i = 0; i < 100 && rso !== 1'b0; i++) @(posedge pclk);
			chk(crst_n, 1);
			// straps and flash flip after release; the captured mode must not follow
			{boot, wide, flash} <= ~rows[r][4:2];
			repeat (4) @(posedge pclk);
			chk(ebm, rows[r][1]);
			chk(aen, rows[r][0]);
			$display("strap row %0d done", r);
		end
		apb(1'b1, 4'h0, 32'h0000000F); // all four pad pull-ups off
		@(posedge pclk);
		chk({p3, p2, p1, p0}, 32'h0000000F);
		apb(1'b0, 4'h0, 32'h00000000);
		chk(q, 32'h0000000F);
		apb(1'b0, 4'hC, 32'h00000000);
		chk(e, 1);
		$display("register test done");
		hold_rst <= 1'b1;
		repeat (3) @(posedge pclk);
		chk(rso, 1);
		chk({p3, p2, p1, p0}, 32'h00000000);
		$display("reset test done");
		print_verdict;
	end
endmodule // tb_reset_and_boot_strap_control
`default_nettype wire
